// [output_delay_tap_pkg.sv]
package output_delay_tap_pkg;

  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 16;
  localparam int TAP_W      = 9;
  localparam int VEC_W      = 54;
  localparam int STEP_W     = 9;

  localparam logic [ADDR_W-1:0] SLICE3_OFFSET = 8'h0e;
  localparam logic [ADDR_W-1:0] SLICE4_OFFSET = 8'h0f;

  localparam int TAP_LSB    = 0;
  localparam int TAP_MSB    = 8;
  localparam int RSVD_LSB   = 9;
  localparam int RSVD_MSB   = 12;
  localparam int COARSE_BIT = 13;
  localparam int DEC_BIT    = 14;
  localparam int INC_BIT    = 15;

  localparam int SLICE3_VEC_LSB = 27;
  localparam int SLICE4_VEC_LSB = 36;

  localparam logic [TAP_W-1:0]  TAP_RESET   = 9'h000;
  localparam logic [TAP_W-1:0]  TAP_ONE     = 9'h001;
  localparam logic [DATA_W-1:0] RDATA_IDLE  = 16'h0000;
  localparam logic [VEC_W-1:0]  VEC_ZERO    = 54'h0;

  // Command patterns as {coarse, step_down, step_up}.
  localparam logic [2:0] CMD_INC       = 3'h1;
  localparam logic [2:0] CMD_DEC       = 3'h2;
  localparam logic [2:0] CMD_COARSE_UP = 3'h5;
  localparam logic [2:0] CMD_COARSE_DN = 3'h6;

  typedef struct packed {
    logic coarse_select;
    logic step_down;
    logic step_up;
  } tap_cmd_t;

  typedef struct packed {
    logic             write;
    tap_cmd_t         cmd;
    logic [TAP_W-1:0] value;
  } tap_write_t;

  typedef struct packed {
    logic             load;
    logic [TAP_W-1:0] value;
  } fabric_load_t;

  typedef enum logic [5:0] {
    ACT_HOLD      = 6'h01,
    ACT_LOAD      = 6'h02,
    ACT_STEP_UP   = 6'h04,
    ACT_STEP_DOWN = 6'h08,
    ACT_COARSE_UP = 6'h10,
    ACT_COARSE_DN = 6'h20
  } tap_action_t;

endpackage

// [output_delay_tap_regs.sv]
// How it works
// - A slice-4 write with command 000, 011, 100 or 111 loads the written 9-bit value as the slice-4 tap.
// - Command 001 raises the slice-4 tap by one, wrapping from 0x1ff to zero.
// - Command 010 lowers the slice-4 tap by one, wrapping from zero to 0x1ff.
// - Command 101 adds the coarse step to the slice-4 tap, modulo the 9-bit range.
// - Command 110 subtracts the coarse step from the slice-4 tap, modulo the 9-bit range.
// - Reading bits 8 to 0 of the slice-4 register returns the applied slice-4 tap, which resets to zero.
// - The slice-4 tap drives read vector bits 44 to 36, and a register load acts like a fabric load there.
// - Command bits 13, 14 and 15 act once per write and always read back as zero.
// - The slice-3 register decodes the same commands with wrap-around, loading like fabric bits 35 to 27.
// - The slice-4 register sits at offset 0x0f and its bits 12 to 9 are reserved.
// - Reading bits 8 to 0 of the slice-3 register returns the slice-3 tap, equal to read vector bits 35 to 27.
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
module output_delay_tap_regs (
  input  wire logic                                       clk_in,
  input  wire logic                                       rst_in,
  input  wire logic [output_delay_tap_pkg::ADDR_W-1:0]    reg_addr_in,
  input  wire logic [output_delay_tap_pkg::DATA_W-1:0]    reg_wdata_in,
  input  wire logic                                       reg_write_in,
  input  wire logic                                       reg_read_in,
  output logic [output_delay_tap_pkg::DATA_W-1:0]         reg_rdata_out,
  input  wire logic [output_delay_tap_pkg::STEP_W-1:0]    coarse_step_in,
  input  wire logic [output_delay_tap_pkg::VEC_W-1:0]     fabric_tap_load_vector_in,
  input  wire logic                                       fabric_load_slice3_in,
  input  wire logic                                       fabric_load_slice4_in,
  output logic [output_delay_tap_pkg::VEC_W-1:0]          fabric_tap_read_vector_out
);

  logic                                     hit_slice3;
  logic                                     hit_slice4;
  output_delay_tap_pkg::tap_write_t         wr_slice3;
  output_delay_tap_pkg::tap_write_t         wr_slice4;
  output_delay_tap_pkg::tap_cmd_t           wr_cmd;
  output_delay_tap_pkg::fabric_load_t       fab_slice3;
  output_delay_tap_pkg::fabric_load_t       fab_slice4;
  logic [output_delay_tap_pkg::TAP_W-1:0]   slice3_out_tap_value;
  logic [output_delay_tap_pkg::TAP_W-1:0]   slice4_out_tap_value;
  logic [output_delay_tap_pkg::DATA_W-1:0]  rdata_r;
  logic [output_delay_tap_pkg::DATA_W-1:0]  rdata_nxt;
  logic [output_delay_tap_pkg::DATA_W-1:0]  slice3_word;
  logic [output_delay_tap_pkg::DATA_W-1:0]  slice4_word;
  logic [output_delay_tap_pkg::VEC_W-1:0]   read_vector;

  assign hit_slice3 = (reg_addr_in == output_delay_tap_pkg::SLICE3_OFFSET);
  assign hit_slice4 = (reg_addr_in == output_delay_tap_pkg::SLICE4_OFFSET);

  assign wr_cmd.coarse_select = reg_wdata_in[output_delay_tap_pkg::COARSE_BIT];
  assign wr_cmd.step_down     = reg_wdata_in[output_delay_tap_pkg::DEC_BIT];
  assign wr_cmd.step_up       = reg_wdata_in[output_delay_tap_pkg::INC_BIT];

  // Command bits go straight to the slice as a one-cycle strobe and are never stored.
  assign wr_slice3.write = reg_write_in & hit_slice3;
  assign wr_slice3.cmd   = wr_cmd;
  assign wr_slice3.value = reg_wdata_in[output_delay_tap_pkg::TAP_MSB:output_delay_tap_pkg::TAP_LSB];
  assign wr_slice4.write = reg_write_in & hit_slice4;
  assign wr_slice4.cmd   = wr_cmd;
  assign wr_slice4.value = reg_wdata_in[output_delay_tap_pkg::TAP_MSB:output_delay_tap_pkg::TAP_LSB];

  assign fab_slice3.load  = fabric_load_slice3_in;
  assign fab_slice3.value = fabric_tap_load_vector_in[output_delay_tap_pkg::SLICE3_VEC_LSB +: output_delay_tap_pkg::TAP_W];
  assign fab_slice4.load  = fabric_load_slice4_in;
  assign fab_slice4.value = fabric_tap_load_vector_in[output_delay_tap_pkg::SLICE4_VEC_LSB +: output_delay_tap_pkg::TAP_W];

  tap_adjust u_slice3 (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .sw_write_in    (wr_slice3),
    .fabric_load_in (fab_slice3),
    .coarse_step_in (coarse_step_in),
    .tap_out        (slice3_out_tap_value)
  );

  // The coarse step is sampled in the write cycle, so a change to it lands on the next command.
  tap_adjust u_slice4 (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .sw_write_in    (wr_slice4),
    .fabric_load_in (fab_slice4),
    .coarse_step_in (coarse_step_in),
    .tap_out        (slice4_out_tap_value)
  );

  // Reserved and command bits read as zero.
  assign slice3_word = {7'h00, slice3_out_tap_value};
  assign slice4_word = {7'h00, slice4_out_tap_value};

  assign rdata_nxt = !reg_read_in ? output_delay_tap_pkg::RDATA_IDLE :
                     hit_slice3   ? slice3_word :
                     hit_slice4   ? slice4_word :
                                    output_delay_tap_pkg::RDATA_IDLE;

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_r <= output_delay_tap_pkg::RDATA_IDLE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

  // Slices outside this bank are not modelled, so their fields stay zero.
  always_comb begin
    read_vector = output_delay_tap_pkg::VEC_ZERO;
    read_vector[output_delay_tap_pkg::SLICE3_VEC_LSB +: output_delay_tap_pkg::TAP_W] = slice3_out_tap_value;
    read_vector[output_delay_tap_pkg::SLICE4_VEC_LSB +: output_delay_tap_pkg::TAP_W] = slice4_out_tap_value;
  end

  assign fabric_tap_read_vector_out = read_vector;

  // Helper values that the checks below compare against one cycle later.
  logic [output_delay_tap_pkg::TAP_W-1:0] exp4_up;
  logic [output_delay_tap_pkg::TAP_W-1:0] exp4_down;
  logic [output_delay_tap_pkg::TAP_W-1:0] exp4_cup;
  logic [output_delay_tap_pkg::TAP_W-1:0] exp4_cdn;
  logic [output_delay_tap_pkg::TAP_W-1:0] exp3_up;
  logic [output_delay_tap_pkg::TAP_W-1:0] exp3_down;
  logic [output_delay_tap_pkg::TAP_W-1:0] exp3_cup;
  logic [output_delay_tap_pkg::TAP_W-1:0] exp3_cdn;
  logic [2:0]                             cmd_bits;
  logic                                   cmd_is_load;

  assign exp4_up     = slice4_out_tap_value + output_delay_tap_pkg::TAP_ONE;
  assign exp4_down   = slice4_out_tap_value - output_delay_tap_pkg::TAP_ONE;
  assign exp4_cup    = slice4_out_tap_value + coarse_step_in;
  assign exp4_cdn    = slice4_out_tap_value - coarse_step_in;
  assign exp3_up     = slice3_out_tap_value + output_delay_tap_pkg::TAP_ONE;
  assign exp3_down   = slice3_out_tap_value - output_delay_tap_pkg::TAP_ONE;
  assign exp3_cup    = slice3_out_tap_value + coarse_step_in;
  assign exp3_cdn    = slice3_out_tap_value - coarse_step_in;
  assign cmd_bits    = reg_wdata_in[output_delay_tap_pkg::INC_BIT:output_delay_tap_pkg::COARSE_BIT];
  assign cmd_is_load = (cmd_bits == 3'h0) || (cmd_bits == 3'h1) || (cmd_bits == 3'h6) || (cmd_bits == 3'h7);

  property p_slice4_load;
    @(posedge clk_in) disable iff (rst_in)
    (wr_slice4.write && cmd_is_load) |=> (slice4_out_tap_value == $past(reg_wdata_in[8:0]));
  endproperty
  a_slice4_load: assert property (p_slice4_load) else $error("slice 4 direct load missed");

  property p_slice4_up;
    @(posedge clk_in) disable iff (rst_in)
    (wr_slice4.write && cmd_bits == 3'h4) |=> (slice4_out_tap_value == $past(exp4_up));
  endproperty
  a_slice4_up: assert property (p_slice4_up) else $error("slice 4 step up wrong");

  property p_slice4_down;
    @(posedge clk_in) disable iff (rst_in)
    (wr_slice4.write && cmd_bits == 3'h2) |=> (slice4_out_tap_value == $past(exp4_down));
  endproperty
  a_slice4_down: assert property (p_slice4_down) else $error("slice 4 step down wrong");

  property p_slice4_coarse_up;
    @(posedge clk_in) disable iff (rst_in)
    (wr_slice4.write && cmd_bits == 3'h5) |=> (slice4_out_tap_value == $past(exp4_cup));
  endproperty
  a_slice4_coarse_up: assert property (p_slice4_coarse_up) else $error("slice 4 coarse up wrong");

  property p_slice4_coarse_dn;
    @(posedge clk_in) disable iff (rst_in)
    (wr_slice4.write && cmd_bits == 3'h3) |=> (slice4_out_tap_value == $past(exp4_cdn));
  endproperty
  a_slice4_coarse_dn: assert property (p_slice4_coarse_dn) else $error("slice 4 coarse down wrong");

  property p_slice4_read;
    @(posedge clk_in) disable iff (rst_in)
    (reg_read_in && hit_slice4) |=> (reg_rdata_out == {7'h00, $past(slice4_out_tap_value)});
  endproperty
  a_slice4_read: assert property (p_slice4_read) else $error("slice 4 read data wrong");

  property p_reset_zero;
    @(posedge clk_in)
    rst_in |=> (slice4_out_tap_value == 9'h000 && slice3_out_tap_value == 9'h000 && reg_rdata_out == 16'h0000);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("taps not zero after reset");

  property p_vector_tracks;
    @(posedge clk_in) disable iff (rst_in)
    (fabric_tap_read_vector_out[44:36] == slice4_out_tap_value) &&
    (fabric_tap_read_vector_out[35:27] == slice3_out_tap_value);
  endproperty
  a_vector_tracks: assert property (p_vector_tracks) else $error("read vector differs from taps");

  property p_fabric_load;
    @(posedge clk_in) disable iff (rst_in)
    (fabric_load_slice4_in && !wr_slice4.write) |=>
    (fabric_tap_read_vector_out[44:36] == $past(fabric_tap_load_vector_in[44:36]));
  endproperty
  a_fabric_load: assert property (p_fabric_load) else $error("fabric load of slice 4 missed");

  property p_cmd_bits_zero;
    @(posedge clk_in) disable iff (rst_in)
    reg_read_in |=> (reg_rdata_out[15:9] == 7'h00);
  endproperty
  a_cmd_bits_zero: assert property (p_cmd_bits_zero) else $error("command or reserved bits read back");

  property p_hold;
    @(posedge clk_in) disable iff (rst_in)
    (!wr_slice4.write && !fabric_load_slice4_in) ##1 (!wr_slice4.write && !fabric_load_slice4_in)
    |=> $stable(slice4_out_tap_value);
  endproperty
  a_hold: assert property (p_hold) else $error("slice 4 tap moved without a command");

  property p_slice3_load;
    @(posedge clk_in) disable iff (rst_in)
    (wr_slice3.write && cmd_is_load) |=> (slice3_out_tap_value == $past(reg_wdata_in[8:0]));
  endproperty
  a_slice3_load: assert property (p_slice3_load) else $error("slice 3 direct load missed");

  property p_slice3_steps;
    @(posedge clk_in) disable iff (rst_in)
    (wr_slice3.write && !cmd_is_load) |=>
    (slice3_out_tap_value == ($past(cmd_bits) == 3'h4 ? $past(exp3_up) :
                              $past(cmd_bits) == 3'h2 ? $past(exp3_down) :
                              $past(cmd_bits) == 3'h5 ? $past(exp3_cup) : $past(exp3_cdn)));
  endproperty
  a_slice3_steps: assert property (p_slice3_steps) else $error("slice 3 step result wrong");

  property p_slice3_isolated;
    @(posedge clk_in) disable iff (rst_in)
    (wr_slice4.write && !fabric_load_slice3_in) |=> $stable(slice3_out_tap_value);
  endproperty
  a_slice3_isolated: assert property (p_slice3_isolated) else $error("slice 4 write disturbed slice 3");

  property p_unmapped_read;
    @(posedge clk_in) disable iff (rst_in)
    (reg_read_in && !hit_slice3 && !hit_slice4) |=> (reg_rdata_out == 16'h0000);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_slice3_read;
    @(posedge clk_in) disable iff (rst_in)
    (reg_read_in && hit_slice3) |=> (reg_rdata_out[8:0] == $past(fabric_tap_read_vector_out[35:27]));
  endproperty
  a_slice3_read: assert property (p_slice3_read) else $error("slice 3 read disagrees with vector");

  property p_rdata_one_cycle;
    @(posedge clk_in) disable iff (rst_in)
    !reg_read_in |=> (reg_rdata_out == 16'h0000);
  endproperty
  a_rdata_one_cycle: assert property (p_rdata_one_cycle) else $error("read data outside its cycle");

  // Wrap checks use literal limits so that they do not lean on the same nine-bit adder as the slices.
  property p_slice4_wrap_up;
    @(posedge clk_in) disable iff (rst_in)
    (wr_slice4.write && cmd_bits == 3'h4 && slice4_out_tap_value == 9'h1ff) |=>
    (slice4_out_tap_value == 9'h000);
  endproperty
  a_slice4_wrap_up: assert property (p_slice4_wrap_up) else $error("slice 4 step up did not wrap");

  property p_slice4_wrap_down;
    @(posedge clk_in) disable iff (rst_in)
    (wr_slice4.write && cmd_bits == 3'h2 && slice4_out_tap_value == 9'h000) |=>
    (slice4_out_tap_value == 9'h1ff);
  endproperty
  a_slice4_wrap_down: assert property (p_slice4_wrap_down) else $error("slice 4 step down did not wrap");

  property p_slice3_wrap_up;
    @(posedge clk_in) disable iff (rst_in)
    (wr_slice3.write && cmd_bits == 3'h4 && slice3_out_tap_value == 9'h1ff) |=>
    (slice3_out_tap_value == 9'h000);
  endproperty
  a_slice3_wrap_up: assert property (p_slice3_wrap_up) else $error("slice 3 step up did not wrap");

  property p_slice3_wrap_down;
    @(posedge clk_in) disable iff (rst_in)
    (wr_slice3.write && cmd_bits == 3'h2 && slice3_out_tap_value == 9'h000) |=>
    (slice3_out_tap_value == 9'h1ff);
  endproperty
  a_slice3_wrap_down: assert property (p_slice3_wrap_down) else $error("slice 3 step down did not wrap");

  property p_slice4_cmd_once;
    @(posedge clk_in) disable iff (rst_in)
    (wr_slice4.write && !cmd_is_load) ##1 (!wr_slice4.write && !fabric_load_slice4_in) |=>
    $stable(slice4_out_tap_value);
  endproperty
  a_slice4_cmd_once: assert property (p_slice4_cmd_once) else $error("slice 4 command acted twice");

  property p_slice3_hold;
    @(posedge clk_in) disable iff (rst_in)
    (!wr_slice3.write && !fabric_load_slice3_in) ##1 (!wr_slice3.write && !fabric_load_slice3_in)
    |=> $stable(slice3_out_tap_value);
  endproperty
  a_slice3_hold: assert property (p_slice3_hold) else $error("slice 3 tap moved without a command");

  property p_slice4_isolated;
    @(posedge clk_in) disable iff (rst_in)
    (wr_slice3.write && !fabric_load_slice4_in) |=> $stable(slice4_out_tap_value);
  endproperty
  a_slice4_isolated: assert property (p_slice4_isolated) else $error("slice 3 write disturbed slice 4");

  property p_slice3_fabric_load;
    @(posedge clk_in) disable iff (rst_in)
    (fabric_load_slice3_in && !wr_slice3.write) |=>
    (fabric_tap_read_vector_out[35:27] == $past(fabric_tap_load_vector_in[35:27]));
  endproperty
  a_slice3_fabric_load: assert property (p_slice3_fabric_load) else $error("fabric load of slice 3 missed");

  property p_vector_spare_zero;
    @(posedge clk_in) disable iff (rst_in)
    (fabric_tap_read_vector_out[53:45] == 9'h000) &&
    (fabric_tap_read_vector_out[26:0] == 27'h0000000);
  endproperty
  a_vector_spare_zero: assert property (p_vector_spare_zero) else $error("unused read vector bits not zero");

  property p_reset_vector;
    @(posedge clk_in)
    rst_in |=> (fabric_tap_read_vector_out == 54'h0);
  endproperty
  a_reset_vector: assert property (p_reset_vector) else $error("read vector not zero after reset");

endmodule

// [tap_adjust.sv]
`timescale 1ns/10ps
module tap_adjust (
  input  wire logic                                      clk_in,
  input  wire logic                                      rst_in,
  input  wire output_delay_tap_pkg::tap_write_t          sw_write_in,
  input  wire output_delay_tap_pkg::fabric_load_t        fabric_load_in,
  input  wire logic [output_delay_tap_pkg::STEP_W-1:0]   coarse_step_in,
  output logic [output_delay_tap_pkg::TAP_W-1:0]         tap_out
);

  logic [output_delay_tap_pkg::TAP_W-1:0] tap_r;
  logic [output_delay_tap_pkg::TAP_W-1:0] tap_nxt;
  logic [output_delay_tap_pkg::TAP_W-1:0] up_one;
  logic [output_delay_tap_pkg::TAP_W-1:0] down_one;
  logic [output_delay_tap_pkg::TAP_W-1:0] up_coarse;
  logic [output_delay_tap_pkg::TAP_W-1:0] down_coarse;
  output_delay_tap_pkg::tap_action_t      action;

  // Nine-bit arithmetic wraps by itself at both limits.
  assign up_one      = tap_r + output_delay_tap_pkg::TAP_ONE;
  assign down_one    = tap_r - output_delay_tap_pkg::TAP_ONE;
  assign up_coarse   = tap_r + coarse_step_in;
  assign down_coarse = tap_r - coarse_step_in;

  // A software write wins over a fabric load landing in the same cycle.
  always_comb begin
    if (sw_write_in.write) begin
      case (sw_write_in.cmd)
        output_delay_tap_pkg::CMD_INC:       action = output_delay_tap_pkg::ACT_STEP_UP;
        output_delay_tap_pkg::CMD_DEC:       action = output_delay_tap_pkg::ACT_STEP_DOWN;
        output_delay_tap_pkg::CMD_COARSE_UP: action = output_delay_tap_pkg::ACT_COARSE_UP;
        output_delay_tap_pkg::CMD_COARSE_DN: action = output_delay_tap_pkg::ACT_COARSE_DN;
        default:                             action = output_delay_tap_pkg::ACT_LOAD;
      endcase
    end else if (fabric_load_in.load) begin
      action = output_delay_tap_pkg::ACT_LOAD;
    end else begin
      action = output_delay_tap_pkg::ACT_HOLD;
    end
  end

  always_comb begin
    case (action)
      output_delay_tap_pkg::ACT_LOAD: begin
        tap_nxt = sw_write_in.write ? sw_write_in.value : fabric_load_in.value;
      end
      output_delay_tap_pkg::ACT_STEP_UP:   tap_nxt = up_one;
      output_delay_tap_pkg::ACT_STEP_DOWN: tap_nxt = down_one;
      output_delay_tap_pkg::ACT_COARSE_UP: tap_nxt = up_coarse;
      output_delay_tap_pkg::ACT_COARSE_DN: tap_nxt = down_coarse;
      default:                             tap_nxt = tap_r;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tap_r <= output_delay_tap_pkg::TAP_RESET;
    end else begin
      tap_r <= tap_nxt;
    end
  end

  assign tap_out = tap_r;

endmodule

// [tb.sv]
`timescale 1ns/10ps
module tb;
  logic        clk_in                    = 1'b0;
  logic        rst_in                    = 1'b1;
  logic [7:0]  reg_addr_in               = 8'h00;
  logic [15:0] reg_wdata_in              = 16'h0000;
  logic        reg_write_in              = 1'b0;
  logic        reg_read_in               = 1'b0;
  logic [15:0] reg_rdata_out;
  logic [8:0]  coarse_step_in            = 9'h0a3;
  logic [53:0] fabric_tap_load_vector_in = 54'h0;
  logic        fabric_load_slice3_in     = 1'b0;
  logic        fabric_load_slice4_in     = 1'b0;
  logic [53:0] fabric_tap_read_vector_out;
  logic [8:0]  mdl [2]                   = '{9'h000, 9'h000};
  logic [11:0] seq [10];
  int          mismatches                = 0;
  int          checks_done               = 0;

  always #2.5 clk_in = ~clk_in;

  output_delay_tap_regs u_dut (
    .clk_in                     (clk_in),
    .rst_in                     (rst_in),
    .reg_addr_in                (reg_addr_in),
    .reg_wdata_in               (reg_wdata_in),
    .reg_write_in               (reg_write_in),
    .reg_read_in                (reg_read_in),
    .reg_rdata_out              (reg_rdata_out),
    .coarse_step_in             (coarse_step_in),
    .fabric_tap_load_vector_in  (fabric_tap_load_vector_in),
    .fabric_load_slice3_in      (fabric_load_slice3_in),
    .fabric_load_slice4_in      (fabric_load_slice4_in),
    .fabric_tap_read_vector_out (fabric_tap_read_vector_out)
  );

  // Reference for the tap update; 9-bit arithmetic gives the wrap-around for free.
  function automatic logic [8:0] nxt(input logic [8:0] cur, input logic [2:0] c, input logic [8:0] v,
                                     input logic [8:0] st);
    case (c)
      3'h1: nxt = cur + 9'h001;
      3'h2: nxt = cur - 9'h001;
      3'h5: nxt = cur + st;
      3'h6: nxt = cur - st;
      default: nxt = v;
    endcase
  endfunction

  function automatic logic [53:0] exp_vec();
    return {9'h000, mdl[1], mdl[0], 27'h0};
  endfunction

  task automatic chk(input logic [53:0] got, input logic [53:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude;
    $display("Checks made: %0d, mismatches: %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Strobes rise just after an edge and fall at the taking edge, so writes may run back to back.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clk_in);
    reg_write_in <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clk_in);
    reg_read_in <= 1'b0;
    #1;
    chk({38'h0, reg_rdata_out}, {38'h0, exp}, "read data");
    @(posedge clk_in);
    #1;
    chk({38'h0, reg_rdata_out}, 54'h0, "read data past its cycle");
  endtask

  // Reserved bits are written as ones to show they never read back.
  task automatic cmd(input int s, input logic [2:0] c, input logic [8:0] v);
    logic [7:0] a;
    a = output_delay_tap_pkg::SLICE3_OFFSET + 8'(s);
    wr(a, {c[0], c[1], c[2], 4'hf, v});
    mdl[s] = nxt(mdl[s], c, v, coarse_step_in);
    chk(fabric_tap_read_vector_out, exp_vec(), "tap vector");
    rd(a, {7'h00, mdl[s]});
  endtask

  task automatic fab(input logic l3, input logic l4, input logic [8:0] v3, input logic [8:0] v4);
    fabric_tap_load_vector_in <= {9'h1ff, v4, v3, 27'h5555555};
    fabric_load_slice3_in     <= l3;
    fabric_load_slice4_in     <= l4;
    @(posedge clk_in);
    fabric_load_slice3_in <= 1'b0;
    fabric_load_slice4_in <= 1'b0;
    #1;
    if (l3) mdl[0] = v3;
    if (l4) mdl[1] = v4;
    chk(fabric_tap_read_vector_out, exp_vec(), "fabric load");
  endtask

  initial begin
    #100000;
    mismatches++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    conclude();
  end

  initial begin
    // Step commands carry junk tap values that must be ignored.
    seq = '{{3'h0, 9'h1ff}, {3'h1, 9'h0aa}, {3'h2, 9'h055}, {3'h5, 9'h0aa}, {3'h6, 9'h133},
            {3'h6, 9'h000}, {3'h3, 9'h123}, {3'h4, 9'h0f0}, {3'h7, 9'h1ff}, {3'h2, 9'h055}};
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    chk(fabric_tap_read_vector_out, 54'h0, "vector after reset");
    rd(8'h0e, 16'h0000);
    rd(8'h0f, 16'h0000);
    for (int s = 0; s < 2; s++) begin
      coarse_step_in <= (s == 0) ? 9'h155 : 9'h0a3;
      for (int i = 0; i < 10; i++) begin
        cmd(s, seq[i][11:9], seq[i][8:0]);
      end
    end
    wr(8'h0f, 16'h8000);
    wr(8'h0f, 16'h8000);
    mdl[1] = mdl[1] + 9'h002;
    chk(fabric_tap_read_vector_out, exp_vec(), "back to back steps");
    wr(8'h0d, 16'h0123);
    wr(8'h10, 16'h0123);
    chk(fabric_tap_read_vector_out, exp_vec(), "unmapped writes");
    rd(8'h10, 16'h0000);
    fab(1'b1, 1'b1, 9'h0c3, 9'h1a5);
    rd(8'h0e, 16'h00c3);
    rd(8'h0f, 16'h01a5);
    fab(1'b0, 1'b1, 9'h077, 9'h1fe);
    cmd(1, 3'h1, 9'h000);
    fabric_tap_load_vector_in <= {9'h000, 9'h111, 9'h000, 27'h0};
    fabric_load_slice4_in     <= 1'b1;
    wr(8'h0f, 16'h0077);
    fabric_load_slice4_in <= 1'b0;
    mdl[1] = 9'h077;
    chk(fabric_tap_read_vector_out, exp_vec(), "software beats fabric");
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    #1;
    mdl[0] = 9'h000;
    mdl[1] = 9'h000;
    chk(fabric_tap_read_vector_out, 54'h0, "vector after second reset");
    rd(8'h0f, 16'h0000);
    conclude();
  end
endmodule
